// ===== ibw_buffer.sv
// The implementer's own choices: the APB interface to the registers and the register offsets.
`include "ibw_regs.svh"
`timescale 1ns/1ps
`default_nettype none

module ibw_buffer
  import ibw_pkg::*;
#(
  parameter int DATA_W = 12
) (
  input  wire logic        sys_clk_i,
  input  wire logic        srst_i,
  input  wire logic        ce_i,
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [7:0]  paddr_i,
  input  wire logic [31:0] pwdata_i,
  output var  logic [31:0] prdata_o,
  output var  logic        pready_o,
  output var  logic        pslverr_o,
  input  wire ibw_far_in_t far_i,
  output var  ibw_far_out_t far_o,
  output var  logic        int_req_o,
  output var  logic        irq_o
);

  //////////////////////////////////////////////////////////////////////////
  // State

  logic [DATA_W-1:0]   work_ff;
  logic [DATA_W-1:0]   nxt_work;
  logic [DATA_W-1:0]   tx_buf_ff;
  logic [DATA_W-1:0]   nxt_tx_buf;
  logic [DATA_W-1:0]   rx_buf_ff;
  logic [DATA_W-1:0]   nxt_rx_buf;
  logic [DATA_W-1:0]   rd_word_ff;
  logic [DATA_W-1:0]   nxt_rd_word;
  logic [2:0]          devsel_ff;
  logic [2:0]          nxt_devsel;
  logic                rx_flag_ff;
  logic                nxt_rx_flag;
  logic                tx_flag_ff;
  logic                nxt_tx_flag;
  logic                ie_ff;
  logic                nxt_ie;
  logic                skip_ff;
  logic                nxt_skip;
  logic [`IBW_EV_W-1:0] ev_sts_ff;
  logic [`IBW_EV_W-1:0] nxt_ev_sts;
  logic [`IBW_EV_W-1:0] ev_en_ff;
  logic [`IBW_EV_W-1:0] nxt_ev_en;
  logic [31:0]         prdata_ff;
  logic [31:0]         nxt_prdata;
  logic                slverr_ff;
  logic                nxt_slverr;
  logic                setup_ff;
  logic                nxt_setup;

  //////////////////////////////////////////////////////////////////////////
  // Bus strobes and instruction decode

  logic       setup_cyc;
  logic       access_done;
  logic       wr_en;
  logic [7:0] word_addr;
  logic       iot_hit;
  logic [2:0] fn;
  logic       do_skip_rx;
  logic       do_read;
  logic       do_skip_tx;
  logic       do_send;
  logic       do_ie_set;
  logic       do_ie_clr;
  logic       rx_take;
  logic       rx_overrun;
  logic       mapped;

  assign word_addr   = {paddr_i[7:2], 2'b00};
  assign setup_cyc   = ce_i && psel_i && !penable_i;
  assign pready_o    = ce_i && setup_ff;
  assign access_done = psel_i && penable_i && pready_o;
  assign wr_en       = access_done && pwrite_i && !slverr_ff;

  // Prefix, then device digit from jumper register, then function
  assign iot_hit = wr_en && (word_addr == `IBW_OFS_INSTR)
                   && (pwdata_i[11:6] == `IBW_IOT_PREFIX)
                   && (pwdata_i[`IBW_DEV_MSB:`IBW_DEV_LSB]
                       == devsel_ff);
  assign fn      = pwdata_i[`IBW_FN_MSB:`IBW_FN_LSB];

  assign do_skip_rx = iot_hit && (fn == IBW_FN_SKIP_RX);
  assign do_read    = iot_hit && (fn == IBW_FN_READ);
  assign do_skip_tx = iot_hit && (fn == IBW_FN_SKIP_TX);
  assign do_send    = iot_hit && (fn == IBW_FN_SEND);
  assign do_ie_set  = iot_hit && (fn == IBW_FN_IE_SET);
  assign do_ie_clr  = iot_hit && (fn == IBW_FN_IE_CLR);

  // New word is accepted only into an empty or just-emptied holder
  assign rx_take    = ce_i && far_i.strobe && (!rx_flag_ff || do_read);
  assign rx_overrun = ce_i && far_i.strobe && rx_flag_ff && !do_read;

  always_comb begin
    unique case (word_addr)
      `IBW_OFS_WORK, `IBW_OFS_INSTR, `IBW_OFS_RESULT, `IBW_OFS_RDWORD,
      `IBW_OFS_FLAGS, `IBW_OFS_IRQ_STS, `IBW_OFS_IRQ_CLR, `IBW_OFS_IRQ_EN,
      `IBW_OFS_DEVSEL: mapped = 1'b1;
      default:         mapped = 1'b0;
    endcase
  end

  //////////////////////////////////////////////////////////////////////////
  // Next-state logic

  always_comb begin
    nxt_work    = work_ff;
    nxt_tx_buf  = tx_buf_ff;
    nxt_rx_buf  = rx_buf_ff;
    nxt_rd_word = rd_word_ff;
    nxt_devsel  = devsel_ff;
    nxt_rx_flag = rx_flag_ff;
    nxt_tx_flag = tx_flag_ff;
    nxt_ie      = ie_ff;
    nxt_skip    = skip_ff;
    nxt_ev_en   = ev_en_ff;
    nxt_ev_sts  = ev_sts_ff;
    if (wr_en && word_addr == `IBW_OFS_WORK) begin
      nxt_work = pwdata_i[DATA_W-1:0];
    end
    if (wr_en && word_addr == `IBW_OFS_DEVSEL) begin
      nxt_devsel = pwdata_i[2:0];
    end
    if (wr_en && word_addr == `IBW_OFS_IRQ_EN) begin
      nxt_ev_en = pwdata_i[`IBW_EV_W-1:0];
    end
    if (iot_hit) begin
      nxt_skip = (do_skip_rx && rx_flag_ff)
                 || (do_skip_tx && tx_flag_ff);
    end
    if (do_read) begin
      nxt_rd_word = rx_buf_ff;
      nxt_rx_flag = 1'b0;
    end
    // Far end strobe sets the flag; set beats the read's clear
    if (rx_take) begin
      nxt_rx_buf  = far_i.data;
      nxt_rx_flag = 1'b1;
    end
    // Far end ack clears the flag; a same-cycle send wins
    if (ce_i && far_i.ack) begin
      nxt_tx_flag = 1'b0;
    end
    if (do_send) begin
      nxt_tx_buf  = work_ff;
      nxt_tx_flag = 1'b1;
    end
    if (do_ie_set) begin
      nxt_ie = 1'b1;
    end
    if (do_ie_clr) begin
      nxt_ie = 1'b0;
    end
    // Sticky events: clear first, then set so set wins
    if (wr_en && word_addr == `IBW_OFS_IRQ_CLR) begin
      nxt_ev_sts = ev_sts_ff & ~pwdata_i[`IBW_EV_W-1:0];
    end
    nxt_ev_sts[`IBW_EV_RX]      = nxt_ev_sts[`IBW_EV_RX] | rx_take;
    nxt_ev_sts[`IBW_EV_TXDONE]  = nxt_ev_sts[`IBW_EV_TXDONE]
                                  | (ce_i && far_i.ack && tx_flag_ff);
    nxt_ev_sts[`IBW_EV_OVERRUN] = nxt_ev_sts[`IBW_EV_OVERRUN] | rx_overrun;
  end

  // Read data captured in setup so the access phase has no wait state
  always_comb begin
    nxt_prdata = prdata_ff;
    nxt_slverr = slverr_ff;
    nxt_setup  = setup_ff;
    if (setup_cyc) begin
      nxt_setup  = 1'b1;
      nxt_slverr = !mapped;
      nxt_prdata = 32'h0000_0000;
      unique case (word_addr)
        `IBW_OFS_WORK:    nxt_prdata[DATA_W-1:0] = work_ff;
        `IBW_OFS_RESULT:  nxt_prdata[0] = skip_ff;
        `IBW_OFS_RDWORD:  nxt_prdata[DATA_W-1:0] = rd_word_ff;
        `IBW_OFS_FLAGS: begin
          nxt_prdata[`IBW_FLG_RX] = rx_flag_ff;
          nxt_prdata[`IBW_FLG_TX] = tx_flag_ff;
          nxt_prdata[`IBW_FLG_IE] = ie_ff;
        end
        `IBW_OFS_IRQ_STS: nxt_prdata[`IBW_EV_W-1:0] = ev_sts_ff;
        `IBW_OFS_IRQ_EN:  nxt_prdata[`IBW_EV_W-1:0] = ev_en_ff;
        `IBW_OFS_DEVSEL:  nxt_prdata[2:0] = devsel_ff;
        default:          nxt_prdata = 32'h0000_0000;
      endcase
    end else if (access_done) begin
      nxt_setup = 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Registers

  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      work_ff    <= `IBW_RST_WORD;
      tx_buf_ff  <= `IBW_RST_WORD;
      rx_buf_ff  <= `IBW_RST_WORD;
      rd_word_ff <= `IBW_RST_WORD;
      devsel_ff  <= `IBW_RST_DEVSEL;
      rx_flag_ff <= 1'b0;
      tx_flag_ff <= 1'b0;
      ie_ff      <= 1'b0;
      skip_ff    <= 1'b0;
      ev_sts_ff  <= `IBW_RST_EV;
      ev_en_ff   <= `IBW_RST_EV;
      prdata_ff  <= 32'h0000_0000;
      slverr_ff  <= 1'b0;
      setup_ff   <= 1'b0;
    end else if (ce_i) begin
      work_ff    <= nxt_work;
      tx_buf_ff  <= nxt_tx_buf;
      rx_buf_ff  <= nxt_rx_buf;
      rd_word_ff <= nxt_rd_word;
      devsel_ff  <= nxt_devsel;
      rx_flag_ff <= nxt_rx_flag;
      tx_flag_ff <= nxt_tx_flag;
      ie_ff      <= nxt_ie;
      skip_ff    <= nxt_skip;
      ev_sts_ff  <= nxt_ev_sts;
      ev_en_ff   <= nxt_ev_en;
      prdata_ff  <= nxt_prdata;
      slverr_ff  <= nxt_slverr;
      setup_ff   <= nxt_setup;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Outputs

  assign prdata_o      = prdata_ff;
  assign pslverr_o     = pready_o && slverr_ff;
  assign far_o.data    = tx_buf_ff;
  assign far_o.tx_flag = tx_flag_ff;
  // Far end paces itself on this; no rate limit is needed here
  assign far_o.rx_flag = rx_flag_ff;
  assign int_req_o     = ie_ff && (rx_flag_ff || tx_flag_ff);
  assign irq_o         = |(ev_sts_ff & ev_en_ff);

  //////////////////////////////////////////////////////////////////////////
  // Checks

  AST_WRONG_DEVICE: assert property (
    @(posedge sys_clk_i) disable iff (srst_i)
    wr_en && word_addr == `IBW_OFS_INSTR
    && pwdata_i[5:3] != devsel_ff |=> $stable(ie_ff) && $stable(skip_ff))
    else $error("Instruction for another device took effect");

  AST_SKIP_RX: assert property (
    @(posedge sys_clk_i) disable iff (srst_i)
    do_skip_rx |=> skip_ff == $past(rx_flag_ff))
    else $error("Receive skip does not follow receive flag");

  AST_NO_SKIP: assert property (
    @(posedge sys_clk_i) disable iff (srst_i)
    iot_hit && !do_skip_rx && !do_skip_tx |=> !skip_ff)
    else $error("Non-skip function left a skip request");

  AST_READ: assert property (
    @(posedge sys_clk_i) disable iff (srst_i)
    do_read && !far_i.strobe |=> !rx_flag_ff
    && rd_word_ff == $past(rx_buf_ff))
    else $error("Read did not return word and clear flag");

  AST_SKIP_TX: assert property (
    @(posedge sys_clk_i) disable iff (srst_i)
    do_skip_tx |=> skip_ff == $past(tx_flag_ff))
    else $error("Transmit skip does not follow transmit flag");

  AST_SEND: assert property (
    @(posedge sys_clk_i) disable iff (srst_i)
    do_send |=> tx_flag_ff && far_o.data == $past(work_ff))
    else $error("Send did not present word and set flag");

  AST_IE_SET: assert property (
    @(posedge sys_clk_i) disable iff (srst_i)
    do_ie_set && rx_flag_ff && !do_read |=> int_req_o)
    else $error("Enable with pending flag raised no request");

  AST_IE_CLR: assert property (
    @(posedge sys_clk_i) disable iff (srst_i)
    do_ie_clr ##1 (ce_i && !do_ie_set) [*2] |-> !int_req_o)
    else $error("Request persists after disable");

  AST_RX_HOLD: assert property (
    @(posedge sys_clk_i) disable iff (srst_i)
    rx_flag_ff && !do_read |=> $stable(rx_buf_ff) && rx_flag_ff)
    else $error("Held incoming word changed before read");

  AST_RX_SET: assert property (
    @(posedge sys_clk_i) disable iff (srst_i)
    ce_i && far_i.strobe && !rx_flag_ff |=> rx_flag_ff
    && rx_buf_ff == $past(far_i.data))
    else $error("Incoming word did not set receive flag");

  // Enabled with the receive flag staying set or being set: request must follow
  AST_INT_REQ: assert property (
    @(posedge sys_clk_i) disable iff (srst_i)
    ce_i && ie_ff && !do_ie_clr
    && ((rx_flag_ff && !do_read) || far_i.strobe) |=> int_req_o)
    else $error("Interrupt request missing with enabled flag");

endmodule

`default_nettype wire

// ===== ibw_regs.svh
// Operation
// - Answer only device codes octal 50-57
// - Twelve-bit word paths in each direction
// - Function 1 skips when receive flag set
// - Function 2 reads word, clears receive flag
// - Function 3 skips when transmit flag set
// - Function 4 loads, presents word, sets transmit flag
// - Function 5 sets interrupt enable
// - Function 6 clears interrupt enable
// - About five thousand words per second suffice
// - Far end is twin buffer or logic
// - Middle digit device, last digit operation
`ifndef IBW_REGS_SVH
`define IBW_REGS_SVH

// Register byte offsets
`define IBW_OFS_WORK     8'h00
`define IBW_OFS_INSTR    8'h04
`define IBW_OFS_RESULT   8'h08
`define IBW_OFS_RDWORD   8'h0c
`define IBW_OFS_FLAGS    8'h10
`define IBW_OFS_IRQ_STS  8'h14
`define IBW_OFS_IRQ_CLR  8'h18
`define IBW_OFS_IRQ_EN   8'h1c
`define IBW_OFS_DEVSEL   8'h20

// Instruction layout: prefix digits, device digit, function digit
`define IBW_IOT_PREFIX   6'h35
`define IBW_DEV_MSB      5
`define IBW_DEV_LSB      3
`define IBW_FN_MSB       2
`define IBW_FN_LSB       0

// Function digits
`define IBW_FN_SKIP_RX   3'h1
`define IBW_FN_READ      3'h2
`define IBW_FN_SKIP_TX   3'h3
`define IBW_FN_SEND      3'h4
`define IBW_FN_IE_SET    3'h5
`define IBW_FN_IE_CLR    3'h6

// Flag register bits
`define IBW_FLG_RX       0
`define IBW_FLG_TX       1
`define IBW_FLG_IE       2

// Sticky event bits
`define IBW_EV_RX        0
`define IBW_EV_TXDONE    1
`define IBW_EV_OVERRUN   2
`define IBW_EV_W         3

// Reset values
`define IBW_RST_DEVSEL   3'h0
`define IBW_RST_WORD     12'h000
`define IBW_RST_EV       3'h0

`endif

// ===== ibw_pkg.sv
`include "ibw_regs.svh"
`default_nettype none

package ibw_pkg;

  typedef enum logic [2:0] {
    IBW_FN_SKIP_RX = `IBW_FN_SKIP_RX,
    IBW_FN_READ    = `IBW_FN_READ,
    IBW_FN_SKIP_TX = `IBW_FN_SKIP_TX,
    IBW_FN_SEND    = `IBW_FN_SEND,
    IBW_FN_IE_SET  = `IBW_FN_IE_SET,
    IBW_FN_IE_CLR  = `IBW_FN_IE_CLR
  } ibw_fn_t;

  // From the far end
  typedef struct packed {
    logic [11:0] data;
    logic        strobe;
    logic        ack;
  } ibw_far_in_t;

  // Toward the far end
  typedef struct packed {
    logic [11:0] data;
    logic        tx_flag;
    logic        rx_flag;
  } ibw_far_out_t;

endpackage

`default_nettype wire

// ===== ibw_far_model.sv
`timescale 1ns/1ps
`default_nettype none

module ibw_far_model
  import ibw_pkg::*;
(
  input  wire logic         sys_clk_i,
  input  wire logic         srst_i,
  input  wire ibw_far_out_t dev_i,
  input  wire logic         push_i,
  input  wire logic [11:0]  push_word_i,
  input  wire logic         ack_en_i,
  output var  ibw_far_in_t  far_o,
  output var  logic [11:0]  taken_o
);
  logic [1:0] wait_ff;

  // Far-end logic: one strobe per word, late ack of sent words
  always_ff @(posedge sys_clk_i) begin
    far_o.strobe <= 1'b0;
    far_o.ack <= 1'b0;
    if (srst_i) begin
      far_o.data <= 12'h000;
      wait_ff <= 2'h0;
      taken_o <= 12'h000;
    end else begin
      // Idle lines toggle, never hold the last word
      far_o.data <= push_i ? push_word_i : ~far_o.data;
      far_o.strobe <= push_i;
      if (dev_i.tx_flag && ack_en_i && !far_o.ack) begin
        wait_ff <= wait_ff + 2'h1;
        if (wait_ff == 2'h3) begin
          far_o.ack <= 1'b1;
          taken_o <= dev_i.data;
        end
      end
    end
  end
endmodule
`default_nettype wire

// ===== ibw_buffer_bench.sv
`include "ibw_regs.svh"
`timescale 1ns/1ps
`default_nettype none

module ibw_buffer_bench;
  import ibw_pkg::*;

  logic         sys_clk, srst, psel, penable, pwrite, pready, pslverr;
  logic         int_req, irq, push, ack_en, err, ce;
  logic [7:0]   paddr;
  logic [31:0]  pwdata, prdata, rd;
  logic [11:0]  push_word, taken;
  ibw_far_in_t  far_in;
  ibw_far_out_t far_out;
  int           miscompares = 0;
  int           n_tests = 0;

  ibw_buffer dut (
    .sys_clk_i(sys_clk), .srst_i(srst), .ce_i(ce), .psel_i(psel),
    .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr),
    .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
    .pslverr_o(pslverr), .far_i(far_in), .far_o(far_out),
    .int_req_o(int_req), .irq_o(irq));

  ibw_far_model far (
    .sys_clk_i(sys_clk), .srst_i(srst), .dev_i(far_out), .push_i(push),
    .push_word_i(push_word), .ack_en_i(ack_en), .far_o(far_in),
    .taken_o(taken));

  initial begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end

  ////////////////////////////////////////////////////////////////////
  task report_and_stop;
    $display("comparisons %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  task timeout_hit;
    miscompares++;
    report_and_stop();
  endtask

  task chk(input string what, input logic [31:0] seen, exp);
    n_tests++;
    if (seen !== exp) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    int n = 0;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    @(posedge sys_clk);
    while (pready !== 1'b1) begin
      if (++n > 20) timeout_hit();
      @(posedge sys_clk);
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // Idle edge lets instruction effects land
    @(posedge sys_clk);
  endtask

  task wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task rdchk(input string what, input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(what, rd, e);
  endtask

  task io_transfer_instruction(input logic [2:0] dev, input logic [2:0] fn);
    wr(`IBW_OFS_INSTR, {20'h0, `IBW_IOT_PREFIX, dev, fn});
  endtask

  task push_in(input logic [11:0] w);
    push_word <= w;
    push <= 1'b1;
    @(posedge sys_clk);
    push <= 1'b0;
    repeat (2) @(posedge sys_clk);
  endtask

  ////////////////////////////////////////////////////////////////////
  task t_reset;
    chk("far out", far_out, 14'h0);
    chk("int req", int_req, 1'b0);
    rdchk("flags", `IBW_OFS_FLAGS, 32'h0);
    rdchk("devsel", `IBW_OFS_DEVSEL, 32'h0);
    apb(1'b0, 8'h40, 32'h0);
    chk("unmapped err", err, 1'b1);
    chk("unmapped data", rd, 32'h0);
    wr(`IBW_OFS_RESULT, 32'h1);
    rdchk("result ro", `IBW_OFS_RESULT, 32'h0);
    $display("t_reset done");
  endtask

  task t_send;
    wr(`IBW_OFS_WORK, 32'ha5c);
    io_transfer_instruction(3'h0, IBW_FN_SEND);
    chk("tx data", far_out.data, 12'ha5c);
    chk("tx flag", far_out.tx_flag, 1'b1);
    chk("no req", int_req, 1'b0);
    io_transfer_instruction(3'h0, IBW_FN_SKIP_TX);
    rdchk("skip tx", `IBW_OFS_RESULT, 32'h1);
    ack_en <= 1'b1;
    for (int n = 0; far_out.tx_flag !== 1'b0; n++) begin
      if (n == 50) timeout_hit();
      @(posedge sys_clk);
    end
    ack_en <= 1'b0;
    chk("far word", taken, 12'ha5c);
    io_transfer_instruction(3'h0, IBW_FN_SKIP_TX);
    rdchk("no skip tx", `IBW_OFS_RESULT, 32'h0);
    $display("t_send done");
  endtask

  task t_recv;
    push_in(12'h3c7);
    chk("rx flag", far_out.rx_flag, 1'b1);
    io_transfer_instruction(3'h0, IBW_FN_SKIP_RX);
    rdchk("skip rx", `IBW_OFS_RESULT, 32'h1);
    push_in(12'h111);
    io_transfer_instruction(3'h0, IBW_FN_READ);
    rdchk("rd word", `IBW_OFS_RDWORD, 32'h3c7);
    rdchk("flags clr", `IBW_OFS_FLAGS, 32'h0);
    io_transfer_instruction(3'h0, IBW_FN_SKIP_RX);
    rdchk("no skip rx", `IBW_OFS_RESULT, 32'h0);
    rdchk("events", `IBW_OFS_IRQ_STS, 32'h7);
    $display("t_recv done");
  endtask

  task t_dev;
    for (int d = 0; d < 8; d++) begin
      wr(`IBW_OFS_DEVSEL, d);
      io_transfer_instruction(3'(d + 1), IBW_FN_IE_SET);
      rdchk("other dev", `IBW_OFS_FLAGS, 32'h0);
      io_transfer_instruction(3'(d), IBW_FN_IE_SET);
      rdchk("ie set", `IBW_OFS_FLAGS, 32'h4);
      io_transfer_instruction(3'(d), IBW_FN_IE_CLR);
      rdchk("ie clr", `IBW_OFS_FLAGS, 32'h0);
    end
    wr(`IBW_OFS_DEVSEL, 32'h0);
    $display("t_dev done");
  endtask

  task t_irq;
    wr(`IBW_OFS_IRQ_CLR, 32'h7);
    wr(`IBW_OFS_IRQ_EN, 32'h1);
    push_in(12'h0f0);
    chk("req no ie", int_req, 1'b0);
    io_transfer_instruction(3'h0, IBW_FN_IE_SET);
    chk("req rx", int_req, 1'b1);
    chk("irq on", irq, 1'b1);
    wr(`IBW_OFS_IRQ_EN, 32'h0);
    chk("irq masked", irq, 1'b0);
    wr(`IBW_OFS_IRQ_EN, 32'h1);
    chk("irq again", irq, 1'b1);
    wr(`IBW_OFS_IRQ_CLR, 32'h1);
    chk("irq cleared", irq, 1'b0);
    io_transfer_instruction(3'h0, IBW_FN_IE_CLR);
    chk("req off", int_req, 1'b0);
    io_transfer_instruction(3'h0, IBW_FN_READ);
    rdchk("rd word 2", `IBW_OFS_RDWORD, 32'h0f0);
    $display("t_irq done");
  endtask

  task t_freeze;
    ce <= 1'b0;
    push_in(12'h5a5);
    chk("frozen rx", far_out.rx_flag, 1'b0);
    ce <= 1'b1;
    rdchk("frozen events", `IBW_OFS_IRQ_STS, 32'h0);
    $display("t_freeze done");
  endtask

  initial begin
    srst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    push = 1'b0;
    push_word = 12'h000;
    ack_en = 1'b0;
    ce = 1'b1;
    repeat (12) @(posedge sys_clk);
    srst <= 1'b0;
    @(posedge sys_clk);
    t_reset();
    t_send();
    t_recv();
    t_dev();
    t_irq();
    t_freeze();
    report_and_stop();
  end
endmodule
`default_nettype wire
